// ===== zdk_defs.svh
// constants for the zone lock and keyed digest command block
// assumes one compilation unit; the guard stops double inclusion
//
// Notes on behaviour
// - data summary walks slots in ascending order, then the OTP zone
// - slots flagged as holding private keys are left out of the data summary
// - matching data summary sets the data zone lock byte to 00
// - mismatch with check enabled returns an error and locks nothing
// - summary reads slot bytes as currently stored, altered top bits included
// - successful lock answers one byte of zero
// - summary check bit is ignored when locking a single slot
// - summary check bit set locks the zone without the summary check
// - mode bits 5..2 name the slot when zone code is 10, else zero
// - zone code 00 config, 01 data and OTP, 10 one slot, 11 error
// - keyed digest opcode 08h; selector bits 3..0 pick slot, all 16 hashed
// - challenge is 0 or 32 bytes, ignored when mode bit 0 set
// - keyed digest answers the 32 byte digest
// - message layout: key, challenge, opcode, mode, selector, zeros, serial fields
// - mode bit 6 clear zeroes serial bytes 2-3 and 4-7
// - temp key in use: mode bit 2 must equal its source flag
// - mode bit 1 picks slot or temporary key for first 32 bytes
// - mode bit 0 picks challenge or temporary key for second 32 bytes
// - lock of an area already locked is refused with an error
// - summary uses the same CRC-16 as the command framing
`ifndef ZDK_DEFS_SVH
`define ZDK_DEFS_SVH
`define ZDK_OP_LOCK    8'h17
`define ZDK_OP_MAC     8'h08
`define ZDK_LOCKED     8'h00
`define ZDK_UNLOCKED   8'h55
`define ZDK_LOCK_OK    8'h00
`define ZDK_ERR_OK     8'h00
`define ZDK_ERR_MISCMP 8'h01
`define ZDK_ERR_PARSE  8'h03
`define ZDK_ERR_EXEC   8'h0F
`define ZDK_CRC_POLY   16'h8005
`define ZDK_CRC_INIT   16'h0000
`define ZDK_OTP_BASE   10'h200
`define ZDK_DATA_END   10'h240
`define ZDK_CFG_BASE   10'h240
`define ZDK_CFG_END    10'h2C0
`define ZDK_MSG_CHAL   10'h020
`define ZDK_MSG_OP     10'h040
`define ZDK_MSG_SN8    10'h04F
`define ZDK_MSG_LEN    10'h058
`define ZDK_RLEN_LOCK  6'h01
`define ZDK_RLEN_MAC   6'h20
`define ZDK_A_CMD      5'h00
`define ZDK_A_STATUS   5'h01
`define ZDK_A_LOCKS    5'h02
`define ZDK_A_TKFLAG   5'h03
`define ZDK_A_RESP     5'h08
`define ZDK_A_TKEY     5'h10
`define ZDK_A_CHAL     5'h18
`endif

// ===== zdk_pkg.sv
// types for the zone lock and keyed digest command block
// assumes zdk_defs.svh holds every number
package zdk_pkg;
	typedef enum logic [2:0] {
		st_idle  = 3'h0,
		st_rd    = 3'h1,
		st_aw    = 3'h3,
		st_use   = 3'h2,
		st_fin   = 3'h6,
		st_waitd = 3'h7
	} zdk_state_t;
	typedef struct packed {
		logic [4:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} zdk_bus_t;
	typedef struct packed {
		logic [9:0] addr;
		logic       rd;
	} zdk_mem_t;
	typedef struct packed {
		logic [7:0] data;
		logic       valid;
		logic       last;
	} zdk_sha_t;
	typedef struct packed {
		logic [15:0] crc;
	} zdk_crc_state_t;
	typedef struct packed {
		zdk_state_t   st;
		logic [7:0]   opcode;
		logic [7:0]   mode;
		logic [15:0]  param2;
		logic [9:0]   ptr;
		logic [9:0]   pend;
		logic         busy;
		logic         done;
		logic [7:0]   err;
		logic [5:0]   rlen;
		logic [7:0]   cfg_lock;
		logic [7:0]   data_lock;
		logic [15:0]  slot_locked;
		logic         tk_valid;
		logic         tk_src;
		logic [255:0] tkey;
		logic [255:0] chal;
		logic [255:0] resp;
		zdk_mem_t     mem;
		zdk_sha_t     sha;
		logic [31:0]  rdata;
	} zdk_regs_t;
endpackage

// ===== zdk_crc16.sv
// crc-16 over a byte stream, bit 0 of each byte first
// assumes clr and en never both high; en takes din in that cycle
`timescale 1ns/100ps
`include "zdk_defs.svh"
module zdk_crc16 (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        clr,
	input  wire logic        en,
	input  wire logic [7:0]  din,
	output logic      [15:0] crc
);
	zdk_pkg::zdk_crc_state_t s_q;
	zdk_pkg::zdk_crc_state_t s_d;
	logic [15:0]             c;
	logic                    fb;

	always_comb begin
		c = s_q.crc;
		fb = 1'b0;
		for (int i = 0; i < 8; i++) begin
			fb = din[i] ^ c[15];
			c = {c[14:0], 1'b0};
			if (fb)
				c = c ^ `ZDK_CRC_POLY;
		end
		s_d = s_q;
		if (clr)
			s_d.crc = `ZDK_CRC_INIT;
		else if (en)
			s_d.crc = c;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			s_q <= '{crc: `ZDK_CRC_INIT};
		else
			s_q <= s_d;
	end

	assign crc = s_q.crc;
endmodule // zdk_crc16

// ===== zdk_top.sv
// lock and keyed digest command execution with a plain register port
// assumes one-cycle-latency byte memory, external sha engine taking a byte
// per valid, and slot flags and serial number from same-clock logic
`timescale 1ns/100ps
`include "zdk_defs.svh"
module zdk_top (
	input  wire logic                  clk,
	input  wire logic                  nrst,
	input  wire zdk_pkg::zdk_bus_t     bus,
	output logic               [31:0]  rdata,
	output zdk_pkg::zdk_mem_t          mem,
	input  wire logic          [7:0]   mem_rdata,
	input  wire logic          [15:0]  priv_key_slots,
	input  wire logic          [71:0]  serial_number_bytes,
	output zdk_pkg::zdk_sha_t          sha,
	input  wire logic                  sha_done,
	input  wire logic          [255:0] sha_digest
);
	zdk_pkg::zdk_regs_t s_q;
	zdk_pkg::zdk_regs_t s_d;
	logic [15:0]        crc;
	logic               crc_clr;
	logic               crc_en;
	logic               fin;
	logic               do_lock;
	logic [7:0]         ferr;
	logic [1:0]         zone;
	logic               tk_use;
	logic               skip;
	logic [7:0]         kb;
	logic [7:0]         cb;
	logic [7:0]         msg;
	logic [3:0]         rel;
	logic [3:0]         snn;
	logic [9:0]         nxt;

	zdk_crc16 u_crc (
		.clk  (clk),
		.nrst (nrst),
		.clr  (crc_clr),
		.en   (crc_en),
		.din  (mem_rdata),
		.crc  (crc)
	);

	assign zone = s_q.mode[1:0];
	assign tk_use = s_q.mode[0] | s_q.mode[1];
	assign nxt = s_q.ptr + 10'h001;

	// message byte at ptr; slot bytes arrive on mem_rdata
	always_comb begin
		kb = 8'(s_q.tkey >> {~s_q.ptr[4:0], 3'b000});
		cb = 8'(s_q.chal >> {~s_q.ptr[4:0], 3'b000});
		rel = 4'(s_q.ptr - `ZDK_MSG_SN8);
		snn = 4'h0;
		msg = 8'h00;
		unique case (rel)
			4'h0: snn = 4'h8;
			4'h1, 4'h2, 4'h3, 4'h4: snn = 4'(rel + 4'h3);
			4'h5, 4'h6: snn = 4'(rel - 4'h5);
			default: snn = 4'(rel - 4'h5);
		endcase
		if (s_q.ptr < `ZDK_MSG_CHAL)
			msg = s_q.mode[1] ? kb : mem_rdata;
		else if (s_q.ptr < `ZDK_MSG_OP)
			msg = s_q.mode[0] ? kb : cb;
		else if (s_q.ptr == `ZDK_MSG_OP)
			msg = s_q.opcode;
		else if (s_q.ptr == `ZDK_MSG_OP + 10'h001)
			msg = s_q.mode;
		else if (s_q.ptr == `ZDK_MSG_OP + 10'h002)
			msg = s_q.param2[7:0];
		else if (s_q.ptr == `ZDK_MSG_OP + 10'h003)
			msg = s_q.param2[15:8];
		else if (s_q.ptr >= `ZDK_MSG_SN8) begin
			msg = 8'(serial_number_bytes >> {4'(4'h8 - snn), 3'b000});
			if (!s_q.mode[6] && snn != 4'h8 && snn > 4'h1)
				msg = 8'h00;
		end
	end

	// private key slots never reach the data summary
	assign skip = zone == 2'b01 && s_q.ptr < `ZDK_OTP_BASE
		&& priv_key_slots[s_q.ptr[8:5]];

	always_comb begin
		s_d = s_q;
		s_d.rdata = 32'h0000_0000;
		s_d.mem.rd = 1'b0;
		s_d.sha.valid = 1'b0;
		s_d.sha.last = 1'b0;
		crc_clr = 1'b0;
		crc_en = 1'b0;
		fin = 1'b0;
		do_lock = 1'b0;
		ferr = `ZDK_ERR_OK;
		// writes while busy are dropped so a command sees stable inputs
		if (bus.wr && !s_q.busy) begin
			if (bus.addr == `ZDK_A_CMD) begin
				s_d.opcode = bus.wdata[7:0];
				s_d.mode = bus.wdata[15:8];
				s_d.param2 = bus.wdata[31:16];
				s_d.busy = 1'b1;
				s_d.done = 1'b0;
				s_d.err = `ZDK_ERR_OK;
			end
			if (bus.addr == `ZDK_A_TKFLAG) begin
				s_d.tk_valid = bus.wdata[0];
				s_d.tk_src = bus.wdata[1];
			end
			for (int j = 0; j < 8; j++) begin
				if (bus.addr == 5'(`ZDK_A_TKEY + j))
					s_d.tkey[255 - 32 * j -: 32] = bus.wdata;
				if (bus.addr == 5'(`ZDK_A_CHAL + j))
					s_d.chal[255 - 32 * j -: 32] = bus.wdata;
			end
		end
		if (bus.rd) begin
			if (bus.addr == `ZDK_A_CMD)
				s_d.rdata = {s_q.param2, s_q.mode, s_q.opcode};
			if (bus.addr == `ZDK_A_STATUS)
				s_d.rdata = {10'h000, s_q.rlen, s_q.err, 6'h00, s_q.done, s_q.busy};
			if (bus.addr == `ZDK_A_LOCKS)
				s_d.rdata = {s_q.slot_locked, s_q.data_lock, s_q.cfg_lock};
			if (bus.addr == `ZDK_A_TKFLAG)
				s_d.rdata = {30'h0000_0000, s_q.tk_src, s_q.tk_valid};
			for (int j = 0; j < 8; j++) begin
				if (bus.addr == 5'(`ZDK_A_RESP + j))
					s_d.rdata = s_q.resp[255 - 32 * j -: 32];
				if (bus.addr == 5'(`ZDK_A_TKEY + j))
					s_d.rdata = s_q.tkey[255 - 32 * j -: 32];
				if (bus.addr == 5'(`ZDK_A_CHAL + j))
					s_d.rdata = s_q.chal[255 - 32 * j -: 32];
			end
		end
		unique case (s_q.st)
			zdk_pkg::st_idle: begin
				if (s_q.busy) begin
					crc_clr = 1'b1;
					s_d.ptr = 10'h000;
					if (s_q.opcode == `ZDK_OP_LOCK) begin
						if (s_q.mode[6] || zone == 2'b11
							|| (zone != 2'b10 && s_q.mode[5:2] != 4'h0)) begin
							fin = 1'b1;
							ferr = `ZDK_ERR_PARSE;
						end else if (zone == 2'b00 ? s_q.cfg_lock != `ZDK_UNLOCKED
							: zone == 2'b01 ? s_q.data_lock != `ZDK_UNLOCKED
							: s_q.slot_locked[s_q.mode[5:2]]) begin
							fin = 1'b1;
							ferr = `ZDK_ERR_EXEC;
						end else if (zone == 2'b10 || s_q.mode[7]) begin
							do_lock = 1'b1;
						end else begin
							s_d.ptr = zone == 2'b00 ? `ZDK_CFG_BASE : 10'h000;
							s_d.pend = zone == 2'b00 ? `ZDK_CFG_END : `ZDK_DATA_END;
							s_d.st = zdk_pkg::st_rd;
						end
					end else if (s_q.opcode == `ZDK_OP_MAC) begin
						if (s_q.mode[7] || s_q.mode[5:3] != 3'h0) begin
							fin = 1'b1;
							ferr = `ZDK_ERR_PARSE;
						end else if (tk_use && s_q.mode[2] != s_q.tk_src) begin
							fin = 1'b1;
							ferr = `ZDK_ERR_EXEC;
						end else if (tk_use && !s_q.tk_valid) begin
							fin = 1'b1;
							ferr = `ZDK_ERR_EXEC;
						end else begin
							s_d.pend = `ZDK_MSG_LEN;
							s_d.st = zdk_pkg::st_rd;
						end
					end else begin
						fin = 1'b1;
						ferr = `ZDK_ERR_PARSE;
					end
				end
			end
			zdk_pkg::st_rd: begin
				if (s_q.opcode == `ZDK_OP_LOCK && skip) begin
					s_d.ptr = nxt;
				end else begin
					s_d.mem.rd = 1'b1;
					s_d.mem.addr = s_q.opcode == `ZDK_OP_LOCK ? s_q.ptr
						: {1'b0, s_q.param2[3:0], s_q.ptr[4:0]};
					s_d.st = zdk_pkg::st_aw;
				end
			end
			zdk_pkg::st_aw: s_d.st = zdk_pkg::st_use;
			zdk_pkg::st_use: begin
				s_d.ptr = nxt;
				if (s_q.opcode == `ZDK_OP_LOCK)
					crc_en = 1'b1;
				else begin
					s_d.sha.valid = 1'b1;
					s_d.sha.data = msg;
					s_d.sha.last = nxt == s_q.pend;
				end
				if (nxt != s_q.pend)
					s_d.st = zdk_pkg::st_rd;
				else if (s_q.opcode == `ZDK_OP_LOCK)
					s_d.st = zdk_pkg::st_fin;
				else
					s_d.st = zdk_pkg::st_waitd;
			end
			zdk_pkg::st_fin: begin
				if (crc == s_q.param2)
					do_lock = 1'b1;
				else begin
					fin = 1'b1;
					ferr = `ZDK_ERR_MISCMP;
				end
			end
			zdk_pkg::st_waitd: begin
				if (sha_done) begin
					s_d.resp = sha_digest;
					s_d.rlen = `ZDK_RLEN_MAC;
					fin = 1'b1;
				end
			end
		endcase
		if (do_lock) begin
			unique case (zone)
				2'b00: s_d.cfg_lock = `ZDK_LOCKED;
				2'b01: s_d.data_lock = `ZDK_LOCKED;
				default: s_d.slot_locked[s_q.mode[5:2]] = 1'b1;
			endcase
			s_d.resp = {`ZDK_LOCK_OK, 248'h0};
			s_d.rlen = `ZDK_RLEN_LOCK;
			fin = 1'b1;
		end
		if (fin) begin
			s_d.busy = 1'b0;
			s_d.done = 1'b1;
			s_d.err = ferr;
			s_d.st = zdk_pkg::st_idle;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
			s_q.st <= zdk_pkg::st_idle;
			s_q.cfg_lock <= `ZDK_UNLOCKED;
			s_q.data_lock <= `ZDK_UNLOCKED;
		end else
			s_q <= s_d;
	end

	assign rdata = s_q.rdata;
	assign mem = s_q.mem;
	assign sha = s_q.sha;

	// helper: bytes sent to the sha engine this command
	logic [6:0] vcnt_q;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			vcnt_q <= 7'h00;
		else if (!s_q.busy)
			vcnt_q <= 7'h00;
		else if (s_q.sha.valid)
			vcnt_q <= vcnt_q + 7'h01;
	end

	default clocking cb_a @(posedge clk); endclocking
	default disable iff (!nrst);

	a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 32'h0000_0000)
		else $error("read data outside read answer cycle");
	a_msg_length: assert property (sha.valid && sha.last |-> vcnt_q == 7'h57)
		else $error("message last byte not the 88th");
	a_msg_opcode: assert property (sha.valid && vcnt_q == 7'h40 |-> sha.data == `ZDK_OP_MAC)
		else $error("opcode byte misplaced");
	a_sn_masked: assert property (sha.valid && vcnt_q == 7'h50 && !s_q.mode[6]
		|-> sha.data == 8'h00)
		else $error("serial byte not zeroed");
	a_key_temporary_key_register: assert property (sha.valid && vcnt_q == 7'h00 && s_q.mode[1]
		|-> sha.data == s_q.tkey[255:248])
		else $error("first key byte not from temporary key");
	a_zone_illegal: assert property (s_q.st == zdk_pkg::st_idle && s_q.busy
		&& s_q.opcode == `ZDK_OP_LOCK && zone == 2'b11
		|=> s_q.done && s_q.err == `ZDK_ERR_PARSE)
		else $error("illegal zone code not refused");
	a_src_check: assert property (s_q.st == zdk_pkg::st_idle && s_q.busy
		&& s_q.opcode == `ZDK_OP_MAC && s_q.mode[1] && s_q.mode[2] != s_q.tk_src
		&& s_q.mode[7] == 1'b0 && s_q.mode[5:3] == 3'h0
		|=> s_q.err == `ZDK_ERR_EXEC && !s_q.busy)
		else $error("source flag mismatch not refused");
	a_lock_answer: assert property ($changed(s_q.data_lock)
		|-> s_q.data_lock == `ZDK_LOCKED && s_q.rlen == `ZDK_RLEN_LOCK
		&& s_q.resp[255:248] == `ZDK_LOCK_OK)
		else $error("data lock without zero answer");
	a_miscmp_hold: assert property (s_q.st == zdk_pkg::st_fin && crc != s_q.param2
		|=> s_q.err == `ZDK_ERR_MISCMP && $stable(s_q.data_lock)
		&& $stable(s_q.cfg_lock))
		else $error("miscompare locked a zone");
	a_priv_skip: assert property (mem.rd && s_q.opcode == `ZDK_OP_LOCK && zone == 2'b01
		&& mem.addr < `ZDK_OTP_BASE |-> !priv_key_slots[mem.addr[8:5]])
		else $error("private key slot read for summary");

	c_lock_ok: cover property ($changed(s_q.data_lock));
	c_mac_done: cover property (s_q.st == zdk_pkg::st_waitd ##1 s_q.done);
	c_miscmp: cover property (s_q.done && s_q.err == `ZDK_ERR_MISCMP);
endmodule // zdk_top

// ===== zdk_far_model.sv
// memory and hash engine model on the far side of the command block
// assumes the block's registered request ports and one shared clock
`timescale 1ns/100ps
module zdk_far_model (
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire zdk_pkg::zdk_mem_t mem,
	output logic           [7:0]   mem_rdata,
	input  wire zdk_pkg::zdk_sha_t sha,
	output logic                   sha_done,
	output logic           [255:0] sha_digest
);
	logic [7:0] msg [0:87];
	int         cnt;
	int         got;
	int         dly;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mem_rdata  <= 8'h00;
			sha_done   <= 1'b0;
			sha_digest <= '0;
			cnt        <= 0;
			got        <= 0;
			dly        <= 0;
		end else begin
			// data only valid right after a request; flips otherwise
			mem_rdata  <= mem.rd ? (mem.addr[7:0] ^ {mem.addr[9:8], 6'h2B}) : ~mem_rdata;
			sha_done   <= (dly == 1);
			sha_digest <= (dly == 1) ? {8{32'h1F2E3D4C}} : ~sha_digest;
			if (dly != 0)
				dly <= dly - 1;
			if (sha.valid) begin
				if (cnt < 88)
					msg[cnt] <= sha.data;
				cnt <= cnt + 1;
				if (sha.last) begin
					got <= cnt + 1;
					cnt <= 0;
					dly <= 6;
				end
			end
		end
	end
endmodule // zdk_far_model

// ===== zdk_top_test.sv
// self-checking bench for the lock and keyed digest command block
// assumes zdk_far_model answers memory reads and records the byte stream, answering a fixed digest
`timescale 1ns/100ps
`include "zdk_defs.svh"
module zdk_top_test;
	logic                clk = 1'b0;
	logic                nrst = 1'b0;
	zdk_pkg::zdk_bus_t   bus = '0;
	logic        [31:0]  rdata;
	zdk_pkg::zdk_mem_t   mem;
	logic        [7:0]   mem_rdata;
	logic        [15:0]  pk = 16'h0012;
	logic        [71:0]  sn = 72'h0123456789ABCDEF5A;
	zdk_pkg::zdk_sha_t   sha;
	logic                sha_done;
	logic        [255:0] sha_digest;
	int                  miscompares = 0;
	int                  total_checks = 0;
	logic        [31:0]  st;
	zdk_top u_zdk_top (.clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata), .mem(mem),
		.mem_rdata(mem_rdata), .priv_key_slots(pk), .serial_number_bytes(sn), .sha(sha),
		.sha_done(sha_done), .sha_digest(sha_digest));
	zdk_far_model u_zdk_far_model (.clk(clk), .nrst(nrst), .mem(mem), .mem_rdata(mem_rdata),
		.sha(sha), .sha_done(sha_done), .sha_digest(sha_digest));
	always #50 clk = ~clk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask
	task automatic rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge clk);
		bus <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk);
		bus <= '0;
		#1 d = rdata;
	endtask
	function automatic logic [7:0] mem_b(input logic [9:0] a);
		return a[7:0] ^ {a[9:8], 6'h2B};
	endfunction
	function automatic logic [7:0] tk_b(input int i);
		return 8'h80 ^ i[7:0];
	endfunction
	function automatic logic [7:0] ch_b(input int i);
		return 8'h40 + i[7:0];
	endfunction
	function automatic logic [7:0] sn_b(input int k);
		return sn[71-8*k -: 8];
	endfunction
	function automatic logic [15:0] crc_data();
		logic [15:0] c;
		logic [7:0]  b;
		c = 16'h0000;
		for (int i = 0; i < 576; i++) begin
			b = mem_b(i[9:0]);
			// private key slots never enter the summary
			if (i < 512 && pk[i / 32])
				continue;
			for (int k = 0; k < 8; k++)
				c = {c[14:0], 1'b0} ^ ((b[k] ^ c[15]) ? 16'h8005 : 16'h0000);
		end
		return c;
	endfunction
	function automatic logic [7:0] exp_b(input int i, input logic [7:0] m, input logic [15:0] p);
		if (i < 32)
			return m[1] ? tk_b(i) : mem_b({1'b0, p[3:0], i[4:0]});
		if (i < 64)
			return m[0] ? tk_b(i - 32) : ch_b(i - 32);
		case (i)
			64: return `ZDK_OP_MAC;
			65: return m;
			66: return p[7:0];
			67: return p[15:8];
			79: return sn_b(8);
			84: return sn_b(0);
			85: return sn_b(1);
			80, 81, 82, 83: return m[6] ? sn_b(i - 76) : 8'h00;
			86, 87: return m[6] ? sn_b(i - 84) : 8'h00;
			default: return 8'h00;
		endcase
	endfunction
	task automatic run(input logic [7:0] op, input logic [7:0] m, input logic [15:0] p,
			input logic [7:0] err);
		int n;
		wr(`ZDK_A_CMD, {p, m, op});
		n = 0;
		st = 32'h1;
		while (st[0] !== 1'b0 && n < 2000) begin
			rd(`ZDK_A_STATUS, st);
			n++;
		end
		if (n >= 2000)
			miscompares++;
		chk(st[15:8], err, "error code");
		chk(st[1], 1'b1, "done flag");
	endtask
	task automatic locks(input logic [31:0] exp);
		logic [31:0] d;
		rd(`ZDK_A_LOCKS, d);
		chk(d, exp, "lock bytes");
	endtask
	task automatic t_reset();
		logic [31:0] d;
		locks({16'h0000, `ZDK_UNLOCKED, `ZDK_UNLOCKED});
		rd(5'h05, d);
		chk(d, 32'h0, "unmapped read");
	endtask
	task automatic t_lock();
		logic [31:0] d;
		logic [15:0] c;
		c = crc_data();
		run(`ZDK_OP_LOCK, 8'h80, 16'h0000, `ZDK_ERR_OK);
		locks({16'h0000, `ZDK_UNLOCKED, `ZDK_LOCKED});
		run(`ZDK_OP_LOCK, 8'h00, 16'h0000, `ZDK_ERR_EXEC);
		run(`ZDK_OP_LOCK, 8'h96, 16'hBEEF, `ZDK_ERR_OK);
		locks({16'h0020, `ZDK_UNLOCKED, `ZDK_LOCKED});
		run(`ZDK_OP_LOCK, 8'h03, 16'h0000, `ZDK_ERR_PARSE);
		run(`ZDK_OP_LOCK, 8'h41, c, `ZDK_ERR_PARSE);
		run(`ZDK_OP_LOCK, 8'h01, c ^ 16'h0001, `ZDK_ERR_MISCMP);
		locks({16'h0020, `ZDK_UNLOCKED, `ZDK_LOCKED});
		run(`ZDK_OP_LOCK, 8'h01, c, `ZDK_ERR_OK);
		locks({16'h0020, `ZDK_LOCKED, `ZDK_LOCKED});
		chk(st[21:16], `ZDK_RLEN_LOCK, "lock answer length");
		rd(`ZDK_A_RESP, d);
		chk(d[31:24], `ZDK_LOCK_OK, "lock answer");
		run(`ZDK_OP_LOCK, 8'h01, c, `ZDK_ERR_EXEC);
	endtask
	task automatic mac(input logic [7:0] m, input logic [15:0] p);
		logic [31:0] d;
		run(`ZDK_OP_MAC, m, p, `ZDK_ERR_OK);
		chk(u_zdk_far_model.got, 32'd88, "message length");
		for (int i = 0; i < 88; i++)
			chk(u_zdk_far_model.msg[i], exp_b(i, m, p), "message byte");
		chk(st[21:16], `ZDK_RLEN_MAC, "digest length");
		for (int j = 0; j < 8; j++) begin
			rd(`ZDK_A_RESP + j[4:0], d);
			chk(d, 32'h1F2E3D4C, "digest word");
		end
	endtask
	task automatic t_mac();
		for (int j = 0; j < 8; j++) begin
			wr(`ZDK_A_TKEY + j[4:0], {tk_b(4*j), tk_b(4*j+1), tk_b(4*j+2), tk_b(4*j+3)});
			wr(`ZDK_A_CHAL + j[4:0], {ch_b(4*j), ch_b(4*j+1), ch_b(4*j+2), ch_b(4*j+3)});
		end
		mac(8'h40, 16'hA5B3);
		mac(8'h00, 16'h0007);
		run(8'h30, 8'h00, 16'h0000, `ZDK_ERR_PARSE);
		run(`ZDK_OP_MAC, 8'h80, 16'h0003, `ZDK_ERR_PARSE);
		run(`ZDK_OP_MAC, 8'h08, 16'h0003, `ZDK_ERR_PARSE);
		run(`ZDK_OP_MAC, 8'h01, 16'h0003, `ZDK_ERR_EXEC);
		// host has run nonce before this point: valid, source flag clear
		wr(`ZDK_A_TKFLAG, 32'h1);
		run(`ZDK_OP_MAC, 8'h05, 16'h0003, `ZDK_ERR_EXEC);
		mac(8'h01, 16'h0003);
		mac(8'h42, 16'hF00C);
		wr(`ZDK_A_TKFLAG, 32'h3);
		mac(8'h46, 16'h0001);
	endtask
	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_lock();
		t_mac();
		print_verdict();
	end
	initial begin
		#5000000;
		miscompares++;
		print_verdict();
	end
endmodule // zdk_top_test
